// ===== design/mcu_pkg.sv
// Package for the microcoded processor control unit: widths, field layout,
// codes, register selects and the clock frequency.
// Assumes a single 100 MHz clock domain.
package mcu_pkg;
  localparam int CLK_MHZ        = 100;
  localparam int DATA_W         = 16;
  localparam int MWORD_W        = 36;
  localparam int SEQ_W          = 12;
  localparam int CS_AW          = 8;
  localparam int LUT_W          = 8;
  localparam int KEY_W          = 2;
  // Run/halt control register values and bit positions
  localparam logic [1:0] CTL_HALT_BIT = 2'h0;
  localparam logic [1:0] CTL_RUN_BIT  = 2'h1;
  localparam logic [15:0] CTL_START   = 16'h0002;
  localparam logic [15:0] CTL_STEP    = 16'h0003;
  // Slave-side register selects (index on the slave address)
  localparam logic [3:0] SREG_CTL   = 4'h0;
  localparam logic [3:0] SREG_ADDR  = 4'h1;
  localparam logic [3:0] SREG_RECV  = 4'h2;
  localparam logic [3:0] SREG_XMIT  = 4'h3;
  localparam logic [3:0] SREG_MOD   = 4'h4;
  localparam logic [3:0] SREG_KEY   = 4'h5;
  localparam logic [3:0] SREG_SEQ   = 4'h6;
  localparam logic [3:0] SREG_STAT  = 4'h7;
  // Microword field positions (lsb, width)
  localparam int F_SEQ_LSB  = 0;   localparam int F_SEQ_W  = 3;
  localparam int F_TM_LSB   = 3;   // ALU mode bit
  localparam int F_AF_LSB   = 4;   localparam int F_AF_W   = 4;
  localparam int F_Y_LSB    = 8;   localparam int F_Y_W    = 2;
  localparam int F_X_LSB    = 10;  localparam int F_X_W    = 3;
  localparam int F_W_LSB    = 13;  localparam int F_W_W    = 3;
  localparam int F_Z_LSB    = 16;
  localparam int F_LL_LSB   = 17;  localparam int F_LL_W   = 4;
  localparam int F_LH_LSB   = 21;  localparam int F_LH_W   = 4;
  localparam int F_LUE_LSB  = 25;  // Lookup enable
  localparam int F_STE_LSB  = 26;  // Status AND enable
  localparam int F_BUS_LSB  = 27;  localparam int F_BUS_W  = 2;
  localparam int F_EOI_LSB  = 29;  // End of instruction
  localparam int F_EF_LSB   = 30;  localparam int F_EF_W   = 2;
  localparam int F_SH_LSB   = 32;  localparam int F_SH_W   = 2;
  localparam int F_HI_LSB   = 34;  localparam int F_HI_W   = 2;
  localparam logic [1:0] Y_LITERAL = 2'h3;
  // Sequence types
  localparam logic [2:0] SQ_NEXT    = 3'h0;
  localparam logic [2:0] SQ_SPECIAL = 3'h1;
  localparam logic [2:0] SQ_BRANCH  = 3'h2;
  localparam logic [2:0] SQ_MSYNC   = 3'h3;
  // Destination codes
  localparam logic [2:0] W_ONES0 = 3'h0;
  localparam logic [2:0] W_LOOP  = 3'h3;
  localparam logic [2:0] W_ONES4 = 3'h4;
  localparam logic [2:0] W_RF_A  = 3'h5;
  localparam logic [2:0] W_RF_T  = 3'h6;
  localparam logic [2:0] W_RF_E  = 3'h7;
  // Bus operation field
  localparam logic [1:0] BOP_NONE  = 2'h0;
  localparam logic [1:0] BOP_READ  = 2'h1;
  localparam logic [1:0] BOP_WRITE = 2'h2;
  localparam logic [1:0] SH_LEFT   = 2'h1;
  localparam logic [1:0] SH_RIGHT  = 2'h2;
  typedef enum logic [1:0] {
    MCU_HALTED = 2'b00,
    MCU_RUN    = 2'b01,
    MCU_STEP   = 2'b10
  } mcu_state_t;
endpackage : mcu_pkg

// ===== design/mcu_control_unit.sv
// Microcoded processor control unit: run/halt control, bus interface
// holding registers, microstep sequencer with look-ahead fetch.
// Assumes control store and lookup table are external synchronous-free ROMs
// read combinationally; bus abort comes from the bus control unit.
//
// Summary of operation
// RULE_01: Writing 2 to the run/halt register starts the processor running.
// RULE_02: Writing 3 to the run/halt register selects single-step operation.
// RULE_03: Master bus cycles wait for the completion acknowledge before going on.
// RULE_04: Bus control unit aborts missing acknowledges; abort taken as an interrupt.
// RULE_05: Address, receive and shiftable transmit registers, all selectable to ALU mux.
// RULE_06: Two-bit protect key drives address bits 16 and 17 on every access.
// RULE_07: Sixteen-bit modifier register holds instruction fields; bits 3..0 are loop counter.
// RULE_08: Sequencer counter upper four bits read zero; low eight address control store.
// RULE_09: Microword register captures 36-bit word; drives current and next step.
// RULE_10: Each control word decodes into thirteen separate fields.
// RULE_11: Sequence field: next, special, branch, memory synchronize, conditional jump.
// RULE_12: Mode bit zero picks logical ALU operations, one picks arithmetic.
// RULE_13: Low literal feeds ALU literal, branch low bits, or special selection.
// RULE_14: Special bit makes literal fields pick modifier fields for next word.
// RULE_15: Destination codes route ALU result, carry to ones flag, loop count.
// RULE_16: Enabled lookup table output ANDs into next word literal fields.
// RULE_17: Next microword is store output ANDed with enabled lookup and status.
// RULE_18: Next control word is fetched while the current one executes.
// RULE_19: Processor is master when addressing, slave when addressed.
// RULE_20: Primary unit accepts requesting module number in slave mode.
// RULE_21: Run/halt register reachable always; other registers only while halted.
// RULE_22: Bit 0 drives halt flag, bit 1 run flag; both set means single step.
// RULE_23: Halt flag sampled at every instruction end; set means halted.
// RULE_24: Slave access to a locked register ends with the timeout abort.
// RULE_25: The abort interval belongs to the bus control unit, in clock cycles.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
module mcu_control_unit
  import mcu_pkg::*;
#(
  parameter bit IS_PRIMARY = 1'b1
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // Control store and lookup table
  output logic [CS_AW-1:0]          cs_addr,
  input  wire logic [MWORD_W-1:0]   cs_data,
  output logic [CS_AW-1:0]          lut_addr,
  input  wire logic [LUT_W-1:0]     lut_data,
  input  wire logic [LUT_W-1:0]     status_terms,
  // Arithmetic section
  input  wire logic [DATA_W-1:0]    alu_result,
  input  wire logic                 alu_carry_out_bit,
  output logic [DATA_W-1:0]         alu_mux_addr,
  output logic [DATA_W-1:0]         alu_mux_recv,
  output logic [DATA_W-1:0]         alu_mux_xmit,
  output logic [DATA_W-1:0]         alu_literal,
  output logic [3:0]                alu_func,
  output logic                      alu_arith,
  output logic [1:0]                alu_y_sel,
  output logic [2:0]                rf_sel,
  output logic                      rf_we,
  output logic                      ones_flag,
  output logic [3:0]                loop_count,
  // Software-visible controls
  input  wire logic                 step_req,
  input  wire logic                 key_we,
  input  wire logic [KEY_W-1:0]     key_wdata,
  output logic                      abort_irq,
  output logic [1:0]                run_state,
  // Master bus side
  output logic [DATA_W-1:0]         bus_addr,
  output logic                      key_address_bit_low,
  output logic                      key_address_bit_high,
  output logic [DATA_W-1:0]         bus_wdata,
  output logic                      bus_req,
  output logic                      bus_wr,
  input  wire logic [DATA_W-1:0]    bus_rdata,
  input  wire logic                 bus_done,
  input  wire logic                 bus_quit,
  // Slave register port
  input  wire logic [3:0]           sl_addr,
  input  wire logic [DATA_W-1:0]    sl_wdata,
  input  wire logic                 sl_wr,
  input  wire logic                 sl_rd,
  output logic [DATA_W-1:0]         sl_rdata,
  output logic                      sl_quit,
  input  wire logic [1:0]           sl_req_module,
  output logic [1:0]                req_module
);

  if (MWORD_W != 36 || CS_AW != 8) begin : g_width_check
    $error("mcu_control_unit: unsupported widths");
  end

  function automatic logic [3:0] fld4(input logic [MWORD_W-1:0] w, input int lsb);
    fld4 = w[lsb +: 4];
  endfunction : fld4

  logic [MWORD_W-1:0] mword_r;
  logic [SEQ_W-1:0]   seq_r;
  logic [DATA_W-1:0]  addr_r;
  logic [DATA_W-1:0]  recv_r;
  logic [DATA_W-1:0]  xmit_r;
  logic [DATA_W-1:0]  mod_r;
  logic [KEY_W-1:0]   key_r;
  logic               halt_ff_r;
  logic               run_ff_r;
  logic               ones_r;
  logic               bus_busy_r;
  logic               abort_r;
  logic [DATA_W-1:0]  sl_rdata_r;
  logic               sl_quit_r;
  logic [1:0]         req_mod_r;
  mcu_state_t         state_r;

  // Decoded fields of the current microword
  logic [2:0] f_seq;
  logic       f_tm;
  logic [3:0] f_af;
  logic [1:0] f_y;
  logic [2:0] f_x;
  logic [2:0] f_w;
  logic       f_z;
  logic [3:0] f_ll;
  logic [3:0] f_lh;
  logic       f_lue;
  logic       f_ste;
  logic [1:0] f_bus;
  logic       f_eoi;
  assign f_seq = mword_r[F_SEQ_LSB +: F_SEQ_W]; // [RULE_10] [RULE_11]
  assign f_tm  = mword_r[F_TM_LSB];
  assign f_af  = fld4(mword_r, F_AF_LSB);
  assign f_y   = mword_r[F_Y_LSB +: F_Y_W];
  assign f_x   = mword_r[F_X_LSB +: F_X_W];
  assign f_w   = mword_r[F_W_LSB +: F_W_W];
  assign f_z   = mword_r[F_Z_LSB];
  assign f_ll  = fld4(mword_r, F_LL_LSB);
  assign f_lh  = fld4(mword_r, F_LH_LSB);
  assign f_lue = mword_r[F_LUE_LSB];
  assign f_ste = mword_r[F_STE_LSB];
  assign f_bus = mword_r[F_BUS_LSB +: F_BUS_W];
  assign f_eoi = mword_r[F_EOI_LSB];

  logic running;
  logic bus_wait;
  logic advance;
  logic at_eoi;
  assign running  = (state_r != MCU_HALTED);
  // Sequencer holds while a master cycle is outstanding
  assign bus_wait = bus_busy_r && !bus_done && !bus_quit; // [RULE_03]
  assign advance  = running && !bus_wait && (state_r != MCU_STEP || step_req);
  assign at_eoi   = advance && f_eoi;

  // Next address: branch types take low literal as low bits
  logic [CS_AW-1:0] next_addr;
  logic             cond_ok;
  assign cond_ok = |(status_terms & {f_lh, f_ll});
  always_comb begin
    next_addr = seq_r[CS_AW-1:0] + 8'h01;
    case (f_seq)
      SQ_NEXT, SQ_SPECIAL, SQ_MSYNC: next_addr = seq_r[CS_AW-1:0] + 8'h01;
      SQ_BRANCH: next_addr = {f_lh, f_ll}; // [RULE_13]
      default: begin
        if (cond_ok) next_addr = {f_lh, f_ll}; // [RULE_11]
      end
    endcase
  end

  // Look-ahead: store is addressed by the next step during execution
  assign cs_addr = next_addr; // [RULE_18]

  // Lookup address from modifier field chosen by the low literal, or from the low literal when the special bit is clear
  logic [3:0] lut_low;
  always_comb begin
    case (f_ll[1:0])
      2'h0: lut_low = mod_r[3:0];
      2'h1: lut_low = mod_r[7:4];
      2'h2: lut_low = mod_r[11:8];
      default: lut_low = mod_r[15:12];
    endcase
  end
  assign lut_addr = {f_lh, (f_z ? lut_low : f_ll)}; // [RULE_16] [RULE_13]

  // Literal modifier applied to the next word
  logic [LUT_W-1:0]   lit_mask;
  logic [MWORD_W-1:0] mword_nxt;
  always_comb begin
    lit_mask = 8'hFF;
    if (f_lue) lit_mask = lit_mask & lut_data; // [RULE_16]
    if (f_ste) lit_mask = lit_mask & status_terms; // [RULE_17]
    if (f_z) lit_mask = lit_mask & {mod_r[7:4], lut_low}; // [RULE_14]
    mword_nxt = cs_data;
    mword_nxt[F_LL_LSB +: F_LL_W] = cs_data[F_LL_LSB +: F_LL_W] & lit_mask[3:0]; // [RULE_17]
    mword_nxt[F_LH_LSB +: F_LH_W] = cs_data[F_LH_LSB +: F_LH_W] & lit_mask[7:4];
  end

  // Sequencer and microword register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seq_r   <= '0;
      mword_r <= '0;
    end else if (advance) begin
      seq_r   <= {4'h0, next_addr}; // [RULE_08]
      mword_r <= mword_nxt; // [RULE_09]
    end
  end

  // Run/halt control and processor state
  logic ctl_wr;
  assign ctl_wr = sl_wr && (sl_addr == SREG_CTL); // [RULE_21]
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      halt_ff_r <= 1'b1;
      run_ff_r  <= 1'b0;
    end else if (ctl_wr) begin
      halt_ff_r <= sl_wdata[CTL_HALT_BIT]; // [RULE_22]
      run_ff_r  <= sl_wdata[CTL_RUN_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= MCU_HALTED;
    end else begin
      case (state_r)
        MCU_HALTED: begin
          if (run_ff_r && halt_ff_r) state_r <= MCU_STEP; // [RULE_02]
          else if (run_ff_r) state_r <= MCU_RUN; // [RULE_01]
        end
        MCU_RUN, MCU_STEP: begin
          // Halt flag alone is honoured at an instruction boundary; clearing both flags halts at once
          if (at_eoi && halt_ff_r && !run_ff_r) state_r <= MCU_HALTED; // [RULE_23]
          else if (!run_ff_r && !halt_ff_r) state_r <= MCU_HALTED;
          else if (run_ff_r && halt_ff_r) state_r <= MCU_STEP;
          else if (run_ff_r) state_r <= MCU_RUN;
        end
        default: state_r <= MCU_HALTED;
      endcase
    end
  end

  // Destination routing
  logic load_addr;
  logic load_xmit;
  logic load_mod;
  assign load_addr = advance && (f_w == W_RF_A); // [RULE_15]
  assign load_xmit = advance && (f_w == W_RF_T);
  assign load_mod  = advance && (f_w == W_RF_E);
  assign rf_we     = advance && (f_w >= W_RF_A);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ones_r <= 1'b0;
    end else if (advance && (f_w == W_ONES0 || f_w == W_ONES4)) begin
      ones_r <= alu_carry_out_bit; // [RULE_15]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) addr_r <= '0;
    else if (load_addr) addr_r <= alu_result; // [RULE_05]
    else if (!running && sl_wr && sl_addr == SREG_ADDR) addr_r <= sl_wdata;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      xmit_r <= '0;
    end else if (load_xmit) begin
      xmit_r <= alu_result;
    end else if (advance && mword_r[F_SH_LSB +: F_SH_W] == SH_LEFT) begin
      xmit_r <= {xmit_r[DATA_W-2:0], 1'b0}; // [RULE_05]
    end else if (advance && mword_r[F_SH_LSB +: F_SH_W] == SH_RIGHT) begin
      xmit_r <= {1'b0, xmit_r[DATA_W-1:1]};
    end else if (!running && sl_wr && sl_addr == SREG_XMIT) begin
      xmit_r <= sl_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mod_r <= '0;
    end else if (load_mod) begin
      mod_r <= alu_result; // [RULE_07]
    end else if (advance && f_w == W_LOOP) begin
      mod_r[3:0] <= alu_result[3:0]; // [RULE_15]
    end else if (!running && sl_wr && sl_addr == SREG_MOD) begin
      mod_r <= sl_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) key_r <= '0;
    else if (key_we) key_r <= key_wdata;
    else if (!running && sl_wr && sl_addr == SREG_KEY) key_r <= sl_wdata[KEY_W-1:0];
  end

  // Master bus cycle
  logic bus_start;
  assign bus_start = advance && (f_bus == BOP_READ || f_bus == BOP_WRITE); // [RULE_19]
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_busy_r <= 1'b0;
      bus_wr     <= 1'b0;
    end else if (bus_start) begin
      bus_busy_r <= 1'b1;
      bus_wr     <= (f_bus == BOP_WRITE);
    end else if (bus_done || bus_quit) begin
      bus_busy_r <= 1'b0; // [RULE_03] [RULE_04]
      bus_wr     <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) recv_r <= '0;
    else if (bus_busy_r && bus_done && !bus_wr) recv_r <= bus_rdata; // [RULE_05]
  end

  // Abort raised as an interrupt; held until the next end of instruction
  always_ff @(posedge ref_clk) begin
    if (!rst_n) abort_r <= 1'b0;
    else if (bus_busy_r && bus_quit) abort_r <= 1'b1; // [RULE_04]
    else if (at_eoi) abort_r <= 1'b0;
  end

  // Slave reads; locked registers answer with the abort
  logic sl_ok;
  assign sl_ok = (sl_addr == SREG_CTL) || !running; // [RULE_21]
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sl_rdata_r <= '0;
      sl_quit_r  <= 1'b0;
    end else begin
      sl_quit_r  <= (sl_rd || sl_wr) && !sl_ok; // [RULE_24]
      sl_rdata_r <= '0;
      if (sl_rd && sl_ok) begin
        case (sl_addr)
          SREG_CTL:  sl_rdata_r <= {14'h0000, run_ff_r, halt_ff_r};
          SREG_ADDR: sl_rdata_r <= addr_r;
          SREG_RECV: sl_rdata_r <= recv_r;
          SREG_XMIT: sl_rdata_r <= xmit_r;
          SREG_MOD:  sl_rdata_r <= mod_r;
          SREG_KEY:  sl_rdata_r <= {14'h0000, key_r};
          SREG_SEQ:  sl_rdata_r <= {4'h0, seq_r};
          SREG_STAT: sl_rdata_r <= {12'h000, abort_r, ones_r, state_r};
          default:   sl_rdata_r <= '0;
        endcase
      end
    end
  end

  // Primary unit latches requesting module number
  always_ff @(posedge ref_clk) begin
    if (!rst_n) req_mod_r <= '0;
    else if (IS_PRIMARY && sl_rd && sl_addr == SREG_STAT) req_mod_r <= sl_req_module; // [RULE_20]
  end

  assign alu_mux_addr         = addr_r; // [RULE_05]
  assign alu_mux_recv         = recv_r;
  assign alu_mux_xmit         = xmit_r;
  assign alu_literal          = (f_y == Y_LITERAL) ? {8'h00, f_lh, f_ll} : 16'h0000; // [RULE_13]
  assign alu_func             = f_af; // [RULE_12]
  assign alu_arith            = f_tm;
  assign alu_y_sel            = f_y;
  assign rf_sel               = f_x;
  assign ones_flag            = ones_r;
  assign loop_count           = mod_r[3:0]; // [RULE_07]
  assign abort_irq            = abort_r;
  assign run_state            = state_r;
  assign bus_addr             = addr_r;
  assign key_address_bit_low  = key_r[0]; // [RULE_06]
  assign key_address_bit_high = key_r[1];
  assign bus_wdata            = xmit_r;
  assign bus_req              = bus_busy_r;
  assign sl_rdata             = sl_rdata_r;
  assign sl_quit              = sl_quit_r;
  assign req_module           = req_mod_r;

endmodule : mcu_control_unit

// ===== test/mcu_bus_partner.sv
// Behavioural model of the backplane side: an addressed slave plus the bus control unit.
// Assumes the master holds bus_req until it has seen bus_done or bus_quit.
`timescale 1ns/1ps
module mcu_bus_partner
  import mcu_pkg::*;
#(
  parameter int DONE_CYC = 3,
  parameter int QUIT_CYC = 8
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Master requests
  input  wire logic              bus_req,
  input  wire logic              bus_wr,
  input  wire logic [DATA_W-1:0] bus_addr,
  // Answers
  output logic                   bus_done,
  output logic [DATA_W-1:0]      bus_rdata,
  output logic                   bus_quit,
  // Scenario control: no module recognises the address
  input  wire logic              no_dev
);
  logic [7:0] cnt_r;
  logic       ans_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r     <= 8'h00;
      ans_r     <= 1'b0;
      bus_done  <= 1'b0;
      bus_quit  <= 1'b0;
      bus_rdata <= 16'hFFFF;
    end else begin
      bus_done  <= 1'b0;
      bus_quit  <= 1'b0;
      // Read data is only meaningful beside bus_done, so it churns otherwise
      bus_rdata <= ~bus_rdata;
      if (!bus_req) begin
        cnt_r <= 8'h00;
        ans_r <= 1'b0;
      end else if (!ans_r) begin
        cnt_r <= cnt_r + 8'h01;
        if (!no_dev && cnt_r == 8'(DONE_CYC - 1)) begin
          bus_done <= 1'b1;
          ans_r    <= 1'b1;
          if (!bus_wr) begin
            bus_rdata <= ~bus_addr;
          end
        end else if (no_dev && cnt_r == 8'(QUIT_CYC - 1)) begin
          bus_quit <= 1'b1;
          ans_r    <= 1'b1;
        end
      end
    end
  end
endmodule : mcu_bus_partner

// ===== test/mcu_cu_assertions.sv
// Checker for the control unit's slave port, run control and master bus cycle.
// Assumes one clock domain and the field layout of the package.
`timescale 1ns/1ps
module mcu_cu_checker
  import mcu_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst_n,
  // Slave port
  input wire logic [3:0]        sl_addr,
  input wire logic [DATA_W-1:0] sl_wdata,
  input wire logic              sl_wr,
  input wire logic              sl_rd,
  input wire logic              sl_quit,
  input wire logic [1:0]        run_state,
  // Master bus
  input wire logic              bus_req,
  input wire logic              bus_done,
  input wire logic              bus_quit,
  input wire logic [DATA_W-1:0] bus_addr,
  input wire logic              abort_irq,
  input wire logic              key_we,
  input wire logic [KEY_W-1:0]  key_wdata,
  input wire logic              key_address_bit_low,
  input wire logic              key_address_bit_high
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [KEY_W-1:0] key_seen_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      key_seen_r <= '0;
    end else if (key_we) begin
      key_seen_r <= key_wdata;
    end
  end

  a_run_start: assert property (sl_wr && sl_addr == SREG_CTL && sl_wdata == CTL_START
    |-> ##2 run_state == MCU_RUN) else $error("run state not entered");
  a_step_start: assert property (sl_wr && sl_addr == SREG_CTL && sl_wdata == CTL_STEP
    |-> ##2 run_state == MCU_STEP) else $error("step state not entered");
  a_halt_now: assert property (sl_wr && sl_addr == SREG_CTL && sl_wdata == 16'h0000
    |-> ##2 run_state == MCU_HALTED) else $error("halt not taken");
  a_locked_quit: assert property ((sl_rd || sl_wr) && run_state == MCU_RUN
    && sl_addr != SREG_CTL |=> sl_quit) else $error("locked access not refused");
  a_ctl_open: assert property ((sl_rd || sl_wr) && sl_addr == SREG_CTL
    |=> !sl_quit) else $error("control access refused");
  a_halted_open: assert property (sl_rd && run_state == MCU_HALTED
    && sl_addr <= SREG_STAT |=> !sl_quit) else $error("halted read refused");
  a_req_hold: assert property (bus_req && !bus_done && !bus_quit |=> bus_req
    && $stable(bus_addr)) else $error("bus request dropped early");
  a_req_release: assert property (bus_req && (bus_done || bus_quit)
    |=> !bus_req) else $error("bus request not released");
  a_abort_set: assert property (bus_req && bus_quit |=> abort_irq)
    else $error("abort not raised");
  a_key_lines: assert property (bus_req |->
    {key_address_bit_high, key_address_bit_low} == key_seen_r) else $error("key lines wrong");

  c_master_done: cover property (bus_req && bus_done);
  c_master_quit: cover property (bus_req && bus_quit);
  c_locked: cover property (sl_rd && run_state == MCU_RUN && sl_addr != SREG_CTL);
endmodule : mcu_cu_checker

bind mcu_control_unit mcu_cu_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .sl_addr(sl_addr), .sl_wdata(sl_wdata),
  .sl_wr(sl_wr), .sl_rd(sl_rd), .sl_quit(sl_quit), .run_state(run_state),
  .bus_req(bus_req), .bus_done(bus_done), .bus_quit(bus_quit), .bus_addr(bus_addr),
  .abort_irq(abort_irq), .key_we(key_we), .key_wdata(key_wdata),
  .key_address_bit_low(key_address_bit_low), .key_address_bit_high(key_address_bit_high)
);

// ===== test/tb_top.sv
// Testbench for the control unit: slave register access, run control, master cycles.
// Assumes the bus partner model and a control store word driven by the bench.
`timescale 1ns/1ps
module tb_top;
  import mcu_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [MWORD_W-1:0] cs_word = '0;
  logic step_req = 1'b0, key_we = 1'b0, sl_wr = 1'b0, sl_rd = 1'b0, no_dev = 1'b0;
  logic [KEY_W-1:0] key_wdata = '0;
  logic [3:0] sl_addr = 4'h0;
  logic [DATA_W-1:0] sl_wdata = '0, bus_rdata, bus_addr, bus_wdata, sl_rdata;
  logic [DATA_W-1:0] mux_a, mux_r, mux_t, d;
  logic [3:0] loop_count;
  logic [1:0] run_state, rq;
  logic [1:0] rq_in = 2'h2;
  logic alu_co = 1'b0;
  logic bus_req, bus_wr, bus_done, bus_quit, sl_quit, abort_irq, k_lo, k_hi, q;
  int error_cnt = 0;
  int checked = 0;
  logic [3:0] sels [3] = '{SREG_ADDR, SREG_XMIT, SREG_MOD};
  logic [15:0] vals [3] = '{16'h1234, 16'h5A3C, 16'hC0D7};

  initial forever #5 ref_clk = ~ref_clk;

  mcu_control_unit DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .cs_addr(), .cs_data(cs_word), .lut_addr(),
    .lut_data(8'hFF), .status_terms(8'hFF), .alu_result(16'h0000), .alu_carry_out_bit(alu_co),
    .alu_mux_addr(mux_a), .alu_mux_recv(mux_r), .alu_mux_xmit(mux_t), .alu_literal(),
    .alu_func(), .alu_arith(), .alu_y_sel(), .rf_sel(), .rf_we(), .ones_flag(),
    .loop_count(loop_count), .step_req(step_req), .key_we(key_we), .key_wdata(key_wdata),
    .abort_irq(abort_irq), .run_state(run_state), .bus_addr(bus_addr),
    .key_address_bit_low(k_lo), .key_address_bit_high(k_hi), .bus_wdata(bus_wdata),
    .bus_req(bus_req), .bus_wr(bus_wr), .bus_rdata(bus_rdata), .bus_done(bus_done),
    .bus_quit(bus_quit), .sl_addr(sl_addr), .sl_wdata(sl_wdata), .sl_wr(sl_wr),
    .sl_rd(sl_rd), .sl_rdata(sl_rdata), .sl_quit(sl_quit), .sl_req_module(rq_in),
    .req_module(rq)
  );

  mcu_bus_partner #(.DONE_CYC(3), .QUIT_CYC(8)) u_bus (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .bus_done(bus_done), .bus_rdata(bus_rdata),
    .bus_quit(bus_quit), .no_dev(no_dev)
  );

  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task test_done;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    sl_wr <= 1'b1;
    sl_addr <= a;
    sl_wdata <= v;
    @(posedge ref_clk);
    sl_wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [15:0] v, output logic qt);
    @(posedge ref_clk);
    sl_rd <= 1'b1;
    sl_addr <= a;
    @(posedge ref_clk);
    sl_rd <= 1'b0;
    #1;
    v = sl_rdata;
    qt = sl_quit;
  endtask : rd

  // 0: request up, 1: request down, 2: abort raised
  task wait_on(input int w);
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      #1;
      if ((w == 0 && bus_req === 1'b1) || (w == 1 && bus_req === 1'b0)
          || (w == 2 && abort_irq === 1'b1)) return;
    end
    error_cnt++;
    $display("unexpected wait %0d: expected event seen timeout", w);
    test_done();
  endtask : wait_on

  // Two microsteps: one loads the word with the bus operation, the next executes it
  task mstep(input logic [1:0] op);
    @(posedge ref_clk);
    cs_word <= MWORD_W'(op) << F_BUS_LSB;
    step_req <= 1'b1;
    @(posedge ref_clk);
    cs_word <= '0;
    @(posedge ref_clk);
    step_req <= 1'b0;
  endtask : mstep

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("run_state", 16'h0000, {14'h0, run_state});
    chk("bus_req", 16'h0000, {15'h0, bus_req});
    for (int i = 0; i < 3; i++) begin
      wr(sels[i], vals[i]);
      rd(sels[i], d, q);
      chk("readback", vals[i], d);
      chk("halted quit", 16'h0000, {15'h0, q});
    end
    chk("alu_mux_addr", 16'h1234, mux_a);
    chk("alu_mux_xmit", 16'h5A3C, mux_t);
    chk("loop_count", 16'h0007, {12'h0, loop_count});
    rd(SREG_SEQ, d, q);
    chk("seq upper", 16'h0000, {12'h0, d[15:12]});
    wr(SREG_CTL, CTL_START);
    @(posedge ref_clk);
    #1;
    chk("run_state", 16'h0001, {14'h0, run_state});
    rd(SREG_ADDR, d, q);
    chk("locked quit", 16'h0001, {15'h0, q});
    wr(SREG_MOD, 16'hFFFF);
    rd(SREG_CTL, d, q);
    chk("control quit", 16'h0000, {15'h0, q});
    wr(SREG_CTL, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk("run_state", 16'h0000, {14'h0, run_state});
    rd(SREG_MOD, d, q);
    chk("modifier kept", 16'hC0D7, d);
    @(posedge ref_clk);
    key_we <= 1'b1;
    key_wdata <= 2'h2;
    @(posedge ref_clk);
    key_we <= 1'b0;
    wr(SREG_CTL, CTL_STEP);
    @(posedge ref_clk);
    #1;
    chk("run_state", 16'h0002, {14'h0, run_state});
    alu_co <= 1'b1;
    mstep(BOP_READ);
    wait_on(0);
    chk("bus_addr", 16'h1234, bus_addr);
    chk("key lines", 16'h0002, {14'h0, k_hi, k_lo});
    chk("bus_wr", 16'h0000, {15'h0, bus_wr});
    wait_on(1);
    chk("alu_mux_recv", 16'hEDCB, mux_r);
    mstep(BOP_WRITE);
    wait_on(0);
    chk("bus_wr", 16'h0001, {15'h0, bus_wr});
    chk("bus_wdata", 16'h5A3C, bus_wdata);
    wait_on(1);
    no_dev <= 1'b1;
    mstep(BOP_READ);
    wait_on(2);
    chk("abort_irq", 16'h0001, {15'h0, abort_irq});
    wr(SREG_CTL, 16'h0000);
    @(posedge ref_clk);
    rd(SREG_RECV, d, q);
    chk("recv reg", 16'hEDCB, d);
    rd(SREG_STAT, d, q);
    chk("status", 16'h000C, d);
    chk("req_module", 16'h0002, {14'h0, rq});
    test_done();
  end
endmodule : tb_top
